// File: common/bdp_defines.svh
// Offsets, field positions, response codes and timing counts of the break and
// dead-time protection block. Included by the package and the design files.
`ifndef BDP_DEFINES_SVH
`define BDP_DEFINES_SVH

`define BDP_NCH        3
`define BDP_AW         12
`define BDP_DT_W       10

`define BDP_ADDR_BDTR  12'h044
`define BDP_ADDR_CHCFG 12'h048
`define BDP_ADDR_CMPM  12'h04c
`define BDP_ADDR_STAT  12'h050

`define BDP_RESP_OKAY  2'b00
`define BDP_RESP_DEC   2'b11

`define BDP_F_MOE      15
`define BDP_F_AOE      14
`define BDP_F_BKP      13
`define BDP_F_BKE      12
`define BDP_F_RUN_OFFSTATE_SEL     11
`define BDP_F_IDLE_OFFSTATE_SEL     10
`define BDP_F_LOCK     8

`define BDP_C_OUT_EN   0
`define BDP_C_COMP_EN  1
`define BDP_C_OUT_POL  2
`define BDP_C_COMP_POL 3
`define BDP_C_IDLE_OUT 4
`define BDP_C_IDLE_CMP 5
`define BDP_C_IS_OUT   6
`define BDP_C_PRELOAD  7

`define BDP_DT_OFS64   7'h40
`define BDP_DT_OFS32   6'h20

`define BDP_CLK_NS     40
`define BDP_DEADTIME_BASE_PERIOD_NS    40
`define BDP_DEADTIME_BASE_PERIOD_CYC   ((`BDP_DEADTIME_BASE_PERIOD_NS + `BDP_CLK_NS - 1) / `BDP_CLK_NS)

`endif

// File: common/bdp_pkg.sv
// Types shared by the protection block and its dead-time generator.
// Assumes the constants header is on the include path.
`include "bdp_defines.svh"

package bdp_pkg;

  typedef enum logic [1:0] {
    BDP_LK_NONE = 2'b00,
    BDP_LK_L1   = 2'b01,
    BDP_LK_L2   = 2'b10,
    BDP_LK_L3   = 2'b11
  } bdp_lock_t;

  typedef struct packed {
    logic                     brk_s1;
    logic                     brk_s2;
    logic                     main_output_enable;
    logic                     auto_output_enable;
    logic                     break_polarity;
    logic                     break_enable_bit;
    logic                     run_offstate_sel;
    logic                     idle_offstate_sel;
    bdp_lock_t                lock;
    logic                     lock_done;
    logic [7:0]               dtg;
    logic [`BDP_NCH*8-1:0]    chcfg;
    logic [`BDP_NCH*4-1:0]    cmpm;
    logic [`BDP_NCH-1:0]      o_p;
    logic [`BDP_NCH-1:0]      o_n;
    logic [`BDP_NCH-1:0]      oe_n_p;
    logic [`BDP_NCH-1:0]      oe_n_n;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [1:0]               rresp;
    logic [31:0]              rdata;
  } bdp_state_t;

  typedef struct packed {
    logic                 ref_d;
    logic [`BDP_DT_W-1:0] cnt;
    logic                 p;
    logic                 n;
  } bdp_dt_state_t;

endpackage

// File: dv/bdp_power_stage.sv
// Power stage and break fault source facing the complementary outputs.
// Assumes outputs and enables change on the timer clock.
`timescale 1ns/1ns
`include "bdp_defines.svh"

module bdp_power_stage (
  input  wire logic [`BDP_NCH-1:0] ch_out,   // Main outputs.
  input  wire logic [`BDP_NCH-1:0] ch_comp,  // Complementary outputs.
  input  wire logic [`BDP_NCH-1:0] oe_p_n,   // Main enables, low on.
  input  wire logic [`BDP_NCH-1:0] oe_c_n,   // Comp. enables, low on.
  input  wire logic                clk,      // Timer clock.
  input  wire logic                brk_on,   // Fault present.
  input  wire logic                brk_hi,   // Fault drives pin high.
  input  wire logic                fail_on,  // Clock failure present.
  output logic                     brk_pin,  // Break pin level.
  output logic                     clk_fail, // Clock failure event.
  output int                       shoot     // Shoot-through cycles.
);
  // The pin rests at the inactive level so a missed polarity shows.
  assign brk_pin  = brk_on ? brk_hi : ~brk_hi;
  assign clk_fail = fail_on;
  int n_shoot = 0;
  assign shoot = n_shoot;
  // Both gates driven high at once would short the half bridge.
  always @(posedge clk) begin
    if (|(ch_out & ch_comp & ~oe_p_n & ~oe_c_n)) begin
      n_shoot <= n_shoot + 1;
    end
  end
endmodule

// File: dv/break_deadtime_protect_tb_top.sv
// Register, break, off-state, lock and dead-time tests of the block.
// Assumes the power stage model and the design share one 25 MHz clock.
`timescale 1ns/1ns
`include "bdp_defines.svh"

module break_deadtime_protect_tb_top;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0;
  logic        arv = 1'b0, rre = 1'b0, upd = 1'b0;
  logic [3:0]  ws = 4'hf;
  logic        brk_on = 1'b0, brk_hi = 1'b1, fail_on = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rdv, rdata;
  logic [2:0]  oc = 3'h0, co, cc, coe, cce, pre;
  logic [8:0]  cmode;
  logic [1:0]  bresp, rresp, rsp;
  logic        aw_rdy, w_rdy, bv, ar_rdy, rv, main_output_enable, brk, cfail;
  int          err_count = 0, comparisons = 0, shoot, i;
  logic [7:0]  dtv[5] = '{8'h00, 8'h7f, 8'h85, 8'hc3, 8'hff};
  int          dte[5] = '{0, 127, 138, 280, 1008};
  logic [31:0] lkc[4] = '{32'h7cff, 32'h0d00, 32'h0200, 32'h0300};
  logic [7:0]  lkh[4] = '{8'hdf, 8'hcf, 8'hc3, 8'h43};

  initial forever #20 clk = ~clk;

  bdp_top u_bdp_top (.REF_CLK(clk), .RST(rst), .AXI_AWADDR(awa), .AXI_AWVALID(awv),
    .AXI_AWREADY(aw_rdy), .AXI_WDATA(wd), .AXI_WSTRB(ws), .AXI_WVALID(wv),
    .AXI_WREADY(w_rdy), .AXI_BRESP(bresp), .AXI_BVALID(bv), .AXI_BREADY(bre),
    .AXI_ARADDR(ara), .AXI_ARVALID(arv), .AXI_ARREADY(ar_rdy), .AXI_RDATA(rdata),
    .AXI_RRESP(rresp), .AXI_RVALID(rv), .AXI_RREADY(rre), .BRK_PIN(brk),
    .CLK_FAIL(cfail), .UPDATE_EVT(upd), .OC_REF(oc), .CH_OUT(co), .CH_COMP(cc),
    .CH_OUT_OE_N(coe), .CH_COMP_OE_N(cce), .MAIN_OUT_EN(main_output_enable), .COMPARE_MODE(cmode),
    .PRELOAD_EN(pre));

  bdp_power_stage u_bdp_power_stage (.ch_out(co), .ch_comp(cc), .oe_p_n(coe),
    .oe_c_n(cce), .clk(clk), .brk_on(brk_on), .brk_hi(brk_hi), .fail_on(fail_on),
    .brk_pin(brk), .clk_fail(cfail), .shoot(shoot));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compared %0d mismatched %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rst_run;
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  // Address and data are released separately, each when its ready is seen.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    @(posedge clk);
    ta = 1'b0;
    tw = 1'b0;
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bre <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (awv && aw_rdy === 1'b1) begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (wv && w_rdy === 1'b1) begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge clk);
    r = bresp;
    bre <= 1'b0;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (ar_rdy !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    rre <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("write resp", 32'h0, {30'h0, r});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(n, e, d);
    chk("read resp", 32'h0, {30'h0, r});
  endtask

  task automatic pulse_upd;
    @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
  endtask

  // Counts cycles with both sides off until the newly active side rises.
  task automatic gap(input int e);
    int c;
    @(posedge clk);
    oc[0] <= ~oc[0];
    c = 0;
    for (int k = 0; k < 1100; k++) begin
      @(posedge clk);
      if ((oc[0] ? co[0] : cc[0]) === 1'b1) break;
      if (co[0] === 1'b0 && cc[0] === 1'b0) c++;
    end
    chk("dead gap", e, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    rst_run();
    rd(`BDP_ADDR_BDTR, 32'h0, "ctrl reset");
    rd(`BDP_ADDR_STAT, 32'h0, "status reset");
    axw(12'h0fc, 32'h1, rsp);
    chk("unmapped wr", 32'h3, {30'h0, rsp});
    axr(12'h0fc, rdv, rsp);
    chk("unmapped rd", 32'h3, {30'h0, rsp});
    chk("unmapped data", 32'h0, rdv);
    $display("test registers done");
    wr(`BDP_ADDR_CHCFG, 32'h53);
    wr(`BDP_ADDR_BDTR, 32'h8000);
    settle();
    chk("oe run off", 32'h1, coe[0]);
    wr(`BDP_ADDR_BDTR, 32'h8800);
    settle();
    chk("oe run on", 32'h0, {coe[0], cce[0]});
    wr(`BDP_ADDR_BDTR, 32'h0000);
    settle();
    chk("oe idle off", 32'h1, coe[0]);
    wr(`BDP_ADDR_BDTR, 32'h0400);
    settle();
    chk("oe idle on", 32'h0, {coe[0], cce[0]});
    chk("idle levels", 32'h2, {co[0], cc[0]});
    rd(`BDP_ADDR_STAT, 32'h2, "status written");
    ws <= 4'h1;
    wr(`BDP_ADDR_BDTR, 32'hffffff55);
    ws <= 4'hf;
    rd(`BDP_ADDR_BDTR, 32'h0455, "strobe merge");
    $display("test off-state done");
    for (i = 0; i < 5; i++) begin
      wr(`BDP_ADDR_BDTR, 32'h8800 | dtv[i]);
      gap(dte[i]);
      gap(dte[i]);
    end
    wr(`BDP_ADDR_CHCFG, 32'h5f);
    settle();
    chk("run polarity", 32'h2, {co[0], cc[0]});
    $display("test dead time done");
    wr(`BDP_ADDR_BDTR, 32'hb000);
    settle();
    chk("moe pin idle", 32'h1, main_output_enable);
    brk_on <= 1'b1;
    settle();
    chk("moe pin high", 32'h0, main_output_enable);
    rd(`BDP_ADDR_BDTR, 32'h3000, "ctrl after break");
    brk_on <= 1'b0;
    brk_hi <= 1'b0;
    // A break still active in the write cycle beats the enable, so clear it first.
    wr(`BDP_ADDR_BDTR, 32'h1000);
    wr(`BDP_ADDR_BDTR, 32'h9000);
    settle();
    chk("moe pin idle low pol", 32'h1, main_output_enable);
    brk_on <= 1'b1;
    settle();
    chk("moe pin low", 32'h0, main_output_enable);
    wr(`BDP_ADDR_BDTR, 32'h8000);
    wr(`BDP_ADDR_BDTR, 32'h8000);
    fail_on <= 1'b1;
    settle();
    chk("moe break off", 32'h1, main_output_enable);
    brk_on <= 1'b0;
    wr(`BDP_ADDR_BDTR, 32'h9000);
    settle();
    chk("moe clock fail", 32'h0, main_output_enable);
    wr(`BDP_ADDR_BDTR, 32'h5000);
    pulse_upd();
    settle();
    chk("auto during break", 32'h0, main_output_enable);
    fail_on <= 1'b0;
    pulse_upd();
    settle();
    chk("auto on update", 32'h1, main_output_enable);
    $display("test break done");
    for (i = 0; i < 4; i++) begin
      rst_run();
      wr(`BDP_ADDR_CHCFG, 32'h40);
      wr(`BDP_ADDR_BDTR, i << 8);
      wr(`BDP_ADDR_BDTR, (i == 0) ? 32'h7fff : 32'h7cff);
      wr(`BDP_ADDR_CHCFG, 32'hdf);
      wr(`BDP_ADDR_CMPM, 32'h7);
      rd(`BDP_ADDR_BDTR, lkc[i], "ctrl locked");
      rd(`BDP_ADDR_CHCFG, {24'h0, lkh[i]}, "chcfg locked");
      rd(`BDP_ADDR_CMPM, (i == 3) ? 32'h0 : 32'h7, "cmpm locked");
      chk("compare mode pins", (i == 3) ? 32'h0 : 32'h7, {29'h0, cmode[2:0]});
      chk("preload pin", (i == 3) ? 32'h0 : 32'h1, {31'h0, pre[0]});
    end
    $display("test locks done");
    chk("shoot through", 32'h0, shoot);
    give_verdict();
  end
endmodule

// File: logic/bdp_deadtime.sv
// Dead-time inserter for one complementary output pair.
// Assumes the reference comes from logic on the same clock.
`timescale 1ns/1ns
`include "bdp_defines.svh"

module bdp_deadtime
  import bdp_pkg::*;
(
  input  wire logic                 clk,    // Timer clock.
  input  wire logic                 rst,    // Synchronous reset, active high.
  input  wire logic                 ref_in, // Reference waveform.
  input  wire logic [`BDP_DT_W-1:0] dt,     // Dead time in clock cycles.
  output logic                      out_p,  // Main output, before polarity.
  output logic                      out_n   // Complementary output.
);

  bdp_dt_state_t s_reg;
  bdp_dt_state_t s_next;

  ////////////////////////////////////////////////////////////////////////////

  // delayed activating edge
  // Both sides drop on a reference change when dt is nonzero; the newly active side waits dt
  // cycles so the two are never on together.
  always_comb begin
    s_next       = s_reg;
    s_next.ref_d = ref_in;
    if (ref_in != s_reg.ref_d) begin
      if (dt == '0) begin
        s_next.p = ref_in;
        s_next.n = ~ref_in;
      end else begin
        s_next.p   = 1'b0;
        s_next.n   = 1'b0;
        s_next.cnt = dt - `BDP_DT_W'(1);
      end
    end else if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - `BDP_DT_W'(1);
    end else begin
      s_next.p = ref_in;
      s_next.n = ~ref_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign out_p = s_reg.p;
  assign out_n = s_reg.n;

  ////////////////////////////////////////////////////////////////////////////

  sequence s_edge;
    (ref_in != s_reg.ref_d) && (dt != '0);
  endsequence

  property p_never_both;
    @(posedge clk) disable iff (rst) !(s_reg.p && s_reg.n);
  endproperty
  a_never_both: assert property (p_never_both) else $error("pair both active");

  property p_edge_off;
    @(posedge clk) disable iff (rst) s_edge |=> (!s_reg.p && !s_reg.n);
  endproperty
  a_edge_off: assert property (p_edge_off) else $error("pair not off at edge");

  property p_gap_hold;
    @(posedge clk) disable iff (rst)
      (s_reg.cnt != '0 && ref_in == s_reg.ref_d) |=> (!s_reg.p && !s_reg.n);
  endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("output on during gap");

endmodule

// File: logic/bdp_top.sv
// Break input, main output enable, off-state selection, write protection
// and dead-time control for complementary timer channels, on AXI4-Lite.
// Assumes the counter supplies per-channel references and update pulses.
`timescale 1ns/1ns
`include "bdp_defines.svh"

// Behaviour
// - Break polarity bit selects pin active level
// - Break enable gates pin and clock-fail sources
// - Run: outputs off unless run off-state set
// - Idle: outputs off unless idle off-state set
// - Level 00 protects nothing
// - Level 01 locks idle levels, break, dead-time
// - Level 10 also locks output-channel polarities, off-states
// - Level 11 also locks output-channel compare mode, preload
// - Protection level writable once after reset
// - Dead time derived from eight-bit setting
// - Setting 0xx: value times base period
// - Setting 10x: (64+low6) times two periods
// - Setting 110: (32+low5) times eight periods
// - Setting 111: (32+low5) times sixteen periods
// - Active enabled break clears main enable at once
// - Auto enable sets main enable on update
module bdp_top
  import bdp_pkg::*;
(
  input  wire logic                    REF_CLK,       // Timer clock, 25 MHz.
  input  wire logic                    RST,           // Synchronous reset.
  input  wire logic [`BDP_AW-1:0]      AXI_AWADDR,    // Write address.
  input  wire logic                    AXI_AWVALID,   // Write address valid.
  output logic                         AXI_AWREADY,   // Write address ready.
  input  wire logic [31:0]             AXI_WDATA,     // Write data.
  input  wire logic [3:0]              AXI_WSTRB,     // Write byte strobes.
  input  wire logic                    AXI_WVALID,    // Write data valid.
  output logic                         AXI_WREADY,    // Write data ready.
  output logic [1:0]                   AXI_BRESP,     // Write response.
  output logic                         AXI_BVALID,    // Write response valid.
  input  wire logic                    AXI_BREADY,    // Write response ready.
  input  wire logic [`BDP_AW-1:0]      AXI_ARADDR,    // Read address.
  input  wire logic                    AXI_ARVALID,   // Read address valid.
  output logic                         AXI_ARREADY,   // Read address ready.
  output logic [31:0]                  AXI_RDATA,     // Read data.
  output logic [1:0]                   AXI_RRESP,     // Read response.
  output logic                         AXI_RVALID,    // Read data valid.
  input  wire logic                    AXI_RREADY,    // Read data ready.
  input  wire logic                    BRK_PIN,       // Break pin, asynchronous.
  input  wire logic                    CLK_FAIL,      // Clock monitor failure.
  input  wire logic                    UPDATE_EVT,    // Update event pulse.
  input  wire logic [`BDP_NCH-1:0]     OC_REF,        // Channel references.
  output logic [`BDP_NCH-1:0]          CH_OUT,        // Channel outputs.
  output logic [`BDP_NCH-1:0]          CH_COMP,       // Complementary outputs.
  output logic [`BDP_NCH-1:0]          CH_OUT_OE_N,   // Output enables, low on.
  output logic [`BDP_NCH-1:0]          CH_COMP_OE_N,  // Comp. enables, low on.
  output logic                         MAIN_OUT_EN,   // Main output enable.
  output logic [`BDP_NCH*3-1:0]        COMPARE_MODE,  // Compare mode per channel.
  output logic [`BDP_NCH-1:0]          PRELOAD_EN     // Compare preload enables.
);

  bdp_state_t             s_reg;
  bdp_state_t             s_next;
  logic                   pin_act;
  logic                   brk_act;
  logic                   moe_eff;
  logic                   wr;
  logic                   rd;
  logic [`BDP_AW-1:0]     waddr;
  logic [`BDP_AW-1:0]     raddr;
  logic [31:0]            wd;
  logic [`BDP_DT_W-1:0]   dt_cyc;
  logic [`BDP_NCH-1:0]    dead_p;
  logic [`BDP_NCH-1:0]    dead_n;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] reg_word(bdp_state_t s, logic [`BDP_AW-1:0] a,
                                           logic moe_now, logic brk_now);
    logic [31:0] v;
    v = 32'h0;
    if (a == `BDP_ADDR_BDTR) begin
      v[`BDP_F_MOE]             = moe_now;
      v[`BDP_F_AOE]             = s.auto_output_enable;
      v[`BDP_F_BKP]             = s.break_polarity;
      v[`BDP_F_BKE]             = s.break_enable_bit;
      v[`BDP_F_RUN_OFFSTATE_SEL]            = s.run_offstate_sel;
      v[`BDP_F_IDLE_OFFSTATE_SEL]            = s.idle_offstate_sel;
      v[`BDP_F_LOCK+1:`BDP_F_LOCK] = s.lock;
      v[7:0]                    = s.dtg;
    end else if (a == `BDP_ADDR_CHCFG) begin
      v[`BDP_NCH*8-1:0] = s.chcfg;
    end else if (a == `BDP_ADDR_CMPM) begin
      v[`BDP_NCH*4-1:0] = s.cmpm;
    end else if (a == `BDP_ADDR_STAT) begin
      v[1:0] = {s.lock_done, brk_now};
    end
    return v;
  endfunction

  function automatic logic addr_ok(logic [`BDP_AW-1:0] a);
    return (a == `BDP_ADDR_BDTR) || (a == `BDP_ADDR_CHCFG) ||
           (a == `BDP_ADDR_CMPM) || (a == `BDP_ADDR_STAT);
  endfunction

  function automatic logic [`BDP_DT_W-1:0] dt_units(logic [7:0] g);
    logic [`BDP_DT_W-1:0] u;
    u = '0;
    casez (g[7:5])
      3'b0??: u = `BDP_DT_W'(g);
      3'b10?: u = `BDP_DT_W'({`BDP_DT_OFS64 + {1'b0, g[5:0]}, 1'b0});
      3'b110: u = `BDP_DT_W'({`BDP_DT_OFS32 + {1'b0, g[4:0]}, 3'b000});
      default: u = `BDP_DT_W'({`BDP_DT_OFS32 + {1'b0, g[4:0]}, 4'h0});
    endcase
    return u;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign pin_act = s_reg.break_polarity ? s_reg.brk_s2 : ~s_reg.brk_s2;
  assign brk_act = s_reg.break_enable_bit & (pin_act | CLK_FAIL);
  // immediate enable clear
  // The gate drops the enable in the same cycle, ahead of the register.
  assign moe_eff = s_reg.main_output_enable & ~brk_act;
  assign dt_cyc  = `BDP_DT_W'(dt_units(s_reg.dtg) * `BDP_DEADTIME_BASE_PERIOD_CYC);

  assign waddr = {AXI_AWADDR[`BDP_AW-1:2], 2'b00};
  assign raddr = {AXI_ARADDR[`BDP_AW-1:2], 2'b00};
  // Address and data are only taken together, so neither can be lost.
  assign wr    = AXI_AWVALID & AXI_WVALID & ~s_reg.bvalid;
  assign rd    = AXI_ARVALID & ~s_reg.rvalid;

  always_comb begin
    logic [31:0] cur;
    cur = reg_word(s_reg, waddr, s_reg.main_output_enable, brk_act);
    for (int b = 0; b < 4; b++) begin
      wd[b*8 +: 8] = AXI_WSTRB[b] ? AXI_WDATA[b*8 +: 8] : cur[b*8 +: 8];
    end
  end

  always_comb begin
    logic [7:0] cf;
    logic [7:0] nc;
    logic       lk;
    s_next        = s_reg;
    s_next.brk_s1 = BRK_PIN;
    s_next.brk_s2 = s_reg.brk_s1;
    cf = 8'h00;
    nc = 8'h00;
    lk = 1'b0;
    if (s_reg.bvalid && AXI_BREADY) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && AXI_RREADY) begin
      s_next.rvalid = 1'b0;
    end
    if (wr) begin
      s_next.bvalid = 1'b1;
      s_next.bresp  = addr_ok(waddr) ? `BDP_RESP_OKAY : `BDP_RESP_DEC;
      if (waddr == `BDP_ADDR_BDTR) begin
        s_next.main_output_enable = wd[`BDP_F_MOE];
        if (s_reg.lock == BDP_LK_NONE) begin
          s_next.auto_output_enable = wd[`BDP_F_AOE];
          s_next.break_polarity = wd[`BDP_F_BKP];
          s_next.break_enable_bit = wd[`BDP_F_BKE];
          s_next.dtg = wd[7:0];
        end
        if (s_reg.lock != BDP_LK_L2 && s_reg.lock != BDP_LK_L3) begin
          s_next.run_offstate_sel = wd[`BDP_F_RUN_OFFSTATE_SEL];
          s_next.idle_offstate_sel = wd[`BDP_F_IDLE_OFFSTATE_SEL];
        end
        if (!s_reg.lock_done) begin
          s_next.lock = bdp_lock_t'(wd[`BDP_F_LOCK+1:`BDP_F_LOCK]);
        end
        s_next.lock_done = 1'b1;
      end else if (waddr == `BDP_ADDR_CHCFG) begin
        for (int i = 0; i < `BDP_NCH; i++) begin
          cf = s_reg.chcfg[i*8 +: 8];
          nc = wd[i*8 +: 8];
          if (s_reg.lock != BDP_LK_NONE) begin
            nc[`BDP_C_IDLE_OUT] = cf[`BDP_C_IDLE_OUT];
            nc[`BDP_C_IDLE_CMP] = cf[`BDP_C_IDLE_CMP];
          end
          if ((s_reg.lock == BDP_LK_L2 || s_reg.lock == BDP_LK_L3) &&
              cf[`BDP_C_IS_OUT]) begin
            nc[`BDP_C_OUT_POL]  = cf[`BDP_C_OUT_POL];
            nc[`BDP_C_COMP_POL] = cf[`BDP_C_COMP_POL];
          end
          lk = (s_reg.lock == BDP_LK_L3) && cf[`BDP_C_IS_OUT];
          if (lk) begin
            nc[`BDP_C_PRELOAD] = cf[`BDP_C_PRELOAD];
          end
          s_next.chcfg[i*8 +: 8] = nc;
        end
      end else if (waddr == `BDP_ADDR_CMPM) begin
        for (int i = 0; i < `BDP_NCH; i++) begin
          if (!(s_reg.lock == BDP_LK_L3 && s_reg.chcfg[i*8 + `BDP_C_IS_OUT])) begin
            s_next.cmpm[i*4 +: 4] = {1'b0, wd[i*4 +: 3]};
          end
        end
      end
    end
    if (s_reg.auto_output_enable && UPDATE_EVT && !brk_act) begin
      s_next.main_output_enable = 1'b1;
    end
    if (brk_act) begin
      s_next.main_output_enable = 1'b0;
    end
    if (rd) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = addr_ok(raddr) ? `BDP_RESP_OKAY : `BDP_RESP_DEC;
      s_next.rdata  = reg_word(s_reg, raddr, moe_eff, brk_act);
    end
    for (int i = 0; i < `BDP_NCH; i++) begin
      cf = s_reg.chcfg[i*8 +: 8];
      if (moe_eff) begin
        s_next.oe_n_p[i] = ~(cf[`BDP_C_IS_OUT] & s_reg.run_offstate_sel & cf[`BDP_C_OUT_EN]);
        s_next.oe_n_n[i] = ~(cf[`BDP_C_IS_OUT] & s_reg.run_offstate_sel & cf[`BDP_C_COMP_EN]);
        s_next.o_p[i]    = dead_p[i] ^ cf[`BDP_C_OUT_POL];
        s_next.o_n[i]    = dead_n[i] ^ cf[`BDP_C_COMP_POL];
      end else begin
        s_next.oe_n_p[i] = ~(cf[`BDP_C_IS_OUT] & s_reg.idle_offstate_sel & cf[`BDP_C_OUT_EN]);
        s_next.oe_n_n[i] = ~(cf[`BDP_C_IS_OUT] & s_reg.idle_offstate_sel & cf[`BDP_C_COMP_EN]);
        s_next.o_p[i]    = cf[`BDP_C_IDLE_OUT];
        s_next.o_n[i]    = cf[`BDP_C_IDLE_CMP];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_reg        <= '0;
      s_reg.oe_n_p <= '1;
      s_reg.oe_n_n <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  genvar g;
  generate
    for (g = 0; g < `BDP_NCH; g++) begin : g_ch
      bdp_deadtime u_dt (
        .clk    (REF_CLK),
        .rst    (RST),
        .ref_in (OC_REF[g]),
        .dt     (dt_cyc),
        .out_p  (dead_p[g]),
        .out_n  (dead_n[g])
      );
      assign COMPARE_MODE[g*3 +: 3] = s_reg.cmpm[g*4 +: 3];
      assign PRELOAD_EN[g]          = s_reg.chcfg[g*8 + `BDP_C_PRELOAD];
    end
  endgenerate

  assign AXI_AWREADY  = wr;
  assign AXI_WREADY   = wr;
  assign AXI_BVALID   = s_reg.bvalid;
  assign AXI_BRESP    = s_reg.bresp;
  assign AXI_ARREADY  = rd;
  assign AXI_RVALID   = s_reg.rvalid;
  assign AXI_RRESP    = s_reg.rresp;
  assign AXI_RDATA    = s_reg.rdata;
  assign CH_OUT       = s_reg.o_p;
  assign CH_COMP      = s_reg.o_n;
  assign CH_OUT_OE_N  = s_reg.oe_n_p;
  assign CH_COMP_OE_N = s_reg.oe_n_n;
  assign MAIN_OUT_EN  = moe_eff;

  ////////////////////////////////////////////////////////////////////////////

  logic wr_bdtr;
  assign wr_bdtr = wr && (waddr == `BDP_ADDR_BDTR);

  property p_pol_low;
    @(posedge REF_CLK) disable iff (RST)
      (s_reg.break_enable_bit && !s_reg.break_polarity && !s_reg.brk_s2) |-> !MAIN_OUT_EN;
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("low break ignored");

  property p_bke_off;
    @(posedge REF_CLK) disable iff (RST)
      (!s_reg.break_enable_bit && s_reg.main_output_enable) |-> MAIN_OUT_EN;
  endproperty
  a_bke_off: assert property (p_bke_off) else $error("disabled break acted");

  property p_brk_clear;
    @(posedge REF_CLK) disable iff (RST)
      (s_reg.break_enable_bit && CLK_FAIL) |-> !MAIN_OUT_EN ##1 !s_reg.main_output_enable;
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("break kept enable");

  property p_auto_set;
    @(posedge REF_CLK) disable iff (RST)
      (s_reg.auto_output_enable && UPDATE_EVT && !brk_act) |=> s_reg.main_output_enable;
  endproperty
  a_auto_set: assert property (p_auto_set) else $error("auto enable missed");

  property p_run_off;
    @(posedge REF_CLK) disable iff (RST)
      (moe_eff && !s_reg.run_offstate_sel) |=> (&CH_OUT_OE_N && &CH_COMP_OE_N);
  endproperty
  a_run_off: assert property (p_run_off) else $error("run outputs not off");

  property p_idle_off;
    @(posedge REF_CLK) disable iff (RST)
      (!moe_eff && !s_reg.idle_offstate_sel) |=> (&CH_OUT_OE_N && &CH_COMP_OE_N);
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle outputs not off");

  property p_open_wr;
    @(posedge REF_CLK) disable iff (RST)
      (wr_bdtr && s_reg.lock == BDP_LK_NONE && AXI_WSTRB[0]) |=>
        s_reg.dtg == $past(AXI_WDATA[7:0]);
  endproperty
  a_open_wr: assert property (p_open_wr) else $error("open write lost");

  property p_l1_lock;
    @(posedge REF_CLK) disable iff (RST)
      (wr_bdtr && s_reg.lock != BDP_LK_NONE) |=>
        ($stable(s_reg.dtg) && $stable(s_reg.break_enable_bit) && $stable(s_reg.auto_output_enable));
  endproperty
  a_l1_lock: assert property (p_l1_lock) else $error("locked field changed");

  property p_l2_lock;
    @(posedge REF_CLK) disable iff (RST)
      (wr_bdtr && s_reg.lock[1]) |=> ($stable(s_reg.run_offstate_sel) && $stable(s_reg.idle_offstate_sel));
  endproperty
  a_l2_lock: assert property (p_l2_lock) else $error("off-state changed");

  property p_l3_lock;
    @(posedge REF_CLK) disable iff (RST)
      (wr && waddr == `BDP_ADDR_CMPM && s_reg.lock == BDP_LK_L3 &&
       s_reg.chcfg[`BDP_C_IS_OUT]) |=> $stable(s_reg.cmpm[2:0]);
  endproperty
  a_l3_lock: assert property (p_l3_lock) else $error("compare mode changed");

  property p_once;
    @(posedge REF_CLK) disable iff (RST)
      s_reg.lock_done |=> $stable(s_reg.lock);
  endproperty
  a_once: assert property (p_once) else $error("lock level rewritten");

  property p_dt_lin;
    @(posedge REF_CLK) disable iff (RST)
      !s_reg.dtg[7] |-> dt_cyc == `BDP_DT_W'(s_reg.dtg);
  endproperty
  a_dt_lin: assert property (p_dt_lin) else $error("linear dead time wrong");

  property p_dt_16;
    @(posedge REF_CLK) disable iff (RST)
      (s_reg.dtg[7:5] == 3'b111) |-> dt_cyc == `BDP_DT_W'((32 + s_reg.dtg[4:0]) * 16);
  endproperty
  a_dt_16: assert property (p_dt_16) else $error("x16 dead time wrong");

endmodule
